/* src/reset_boot_memory_map_control.sv */
// Reset sequencing, program memory decode and boot loader, with its host byte FIFO.
`timescale 1ns/1ns

module host_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Filling side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Draining side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready_out = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];

  always_comb begin
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = (AW+1)'(count + {AW'(0), push} - {AW'(0), pop});
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule : host_byte_fifo

module reset_boot_memory_map_control #(
  parameter int BOOT_WORDS = boot_map_pkg::RAM_WORDS,
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Strap and request pins
  input wire logic memory_map_select_pin_in,
  input wire logic boot_source_select_pin_in,
  input wire logic bus_hold_request_n_in,
  output logic bus_grant_n_out,
  // External memory bus
  output boot_map_pkg::ext_bus_s ext_bus_out,
  output logic bus_released_out,
  input wire logic [23:0] ext_data_in,
  // Host port boot bytes
  input wire logic host_port_valid_in,
  output logic host_port_ready_out,
  input wire logic [7:0] host_port_data_in,
  // Core program memory requests
  input wire logic core_pm_valid_in,
  input wire boot_map_pkg::pm_req_s core_pm_req_in,
  output logic core_pm_ack_out,
  output logic [23:0] core_pm_rdata_out,
  // On-chip ROM
  output logic [12:0] rom_addr_out,
  input wire logic [23:0] rom_data_in,
  // Memory-mapped control registers
  input wire logic reg_valid_in,
  input wire boot_map_pkg::reg_req_s reg_req_in,
  output logic [15:0] reg_rdata_out,
  // Core state
  input wire logic mode_status_we_in,
  input wire logic [6:0] mode_status_wdata_in,
  output logic [6:0] mode_status_word_out,
  input wire logic px_we_in,
  input wire logic [7:0] px_wdata_in,
  output logic [7:0] pm_low_byte_extension_out,
  output logic core_reset_out,
  output logic core_run_out,
  output logic [13:0] start_address_out
);
  // Pin synchronisers: a change is accepted once the second and third stages agree.
  logic [2:0] pin_raw, sync1, sync2, sync3, pin_flt, next_pin_flt;
  assign pin_raw = {bus_hold_request_n_in, boot_source_select_pin_in, memory_map_select_pin_in};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_comb begin
      next_pin_flt[i] = (sync2[i] == sync3[i]) ? sync3[i] : pin_flt[i];
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        // Stages start at the pin's idle level, so the request pin shows no false edge.
        sync1[i] <= (i == 2) ? 1'b1 : 1'b0;
        sync2[i] <= (i == 2) ? 1'b1 : 1'b0;
        sync3[i] <= (i == 2) ? 1'b1 : 1'b0;
        pin_flt[i] <= (i == 2) ? 1'b1 : 1'b0;
      end else begin
        sync1[i] <= pin_raw[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        pin_flt[i] <= next_pin_flt[i];
      end
    end
  end
  logic memory_map_select_pin, boot_source_select_pin, br_req;
  assign memory_map_select_pin = pin_flt[0];
  assign boot_source_select_pin = pin_flt[1];
  assign br_req = !pin_flt[2];

  // Host boot bytes wait in a FIFO; the loader drains only while host booting.
  logic fifo_valid, fifo_ready;
  logic [7:0] fifo_data;
  host_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(host_port_valid_in),
    .in_ready_out(host_port_ready_out),
    .in_data_in(host_port_data_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_ready),
    .out_data_out(fifo_data)
  );

  logic [23:0] pm_ram [boot_map_pkg::RAM_WORDS];

  boot_map_pkg::boot_state_e state, next_state;
  boot_map_pkg::ext_bus_s bus, next_bus;
  logic [15:0] dwait, next_dwait, sysctl, next_sysctl, reg_rdata, next_reg_rdata;
  logic [7:0] px, next_px;
  logic [6:0] mode_status_word, next_mode_status_word;
  logic [1:0] settle, next_settle, byte_sel, next_byte_sel;
  logic [15:0] byte_addr, next_byte_addr;
  logic [10:0] word_idx, next_word_idx;
  logic [15:0] asm_hi, next_asm_hi;
  logic ext_active, next_ext_active, ext_boot, next_ext_boot;
  logic [2:0] ext_cnt, next_ext_cnt;
  logic granted, next_granted, pm_ack, next_pm_ack;
  logic [23:0] pm_rdata, next_pm_rdata;
  logic [13:0] start_addr, next_start_addr;
  logic ram_we;
  logic [10:0] ram_addr;
  logic [23:0] ram_wdata;
  logic byte_take;
  logic [7:0] byte_val;
  logic in_rom, in_ram;
  logic [10:0] ram_index;

  assign rom_addr_out = 13'(core_pm_req_in.addr - boot_map_pkg::ROM_FIRST);

  always_comb begin
    next_state = state;
    next_bus = bus;
    next_dwait = dwait;
    next_sysctl = sysctl;
    next_reg_rdata = reg_rdata;
    next_px = px;
    next_mode_status_word = mode_status_word;
    next_settle = settle;
    next_byte_sel = byte_sel;
    next_byte_addr = byte_addr;
    next_word_idx = word_idx;
    next_asm_hi = asm_hi;
    next_ext_active = ext_active;
    next_ext_boot = ext_boot;
    next_ext_cnt = ext_cnt;
    next_pm_ack = 1'b0;
    next_pm_rdata = pm_rdata;
    next_start_addr = start_addr;
    ram_we = 1'b0;
    ram_addr = '0;
    ram_wdata = '0;
    byte_take = 1'b0;
    byte_val = '0;
    fifo_ready = 1'b0;
    // Grant waits for the cycle after any external access completes.
    next_granted = br_req && !ext_active;
    // Map decode of the core's program address.
    in_rom = dwait[boot_map_pkg::DWAIT_ROMEN_BIT]
      && core_pm_req_in.addr >= boot_map_pkg::ROM_FIRST
      && core_pm_req_in.addr <= boot_map_pkg::ROM_LAST;
    in_ram = memory_map_select_pin ? (core_pm_req_in.addr >= boot_map_pkg::RAM_HIGH_BASE)
      : (core_pm_req_in.addr < boot_map_pkg::ROM_FIRST);
    ram_index = 11'(core_pm_req_in.addr);

    if (mode_status_we_in) begin
      next_mode_status_word = mode_status_wdata_in;
    end
    if (px_we_in) begin
      next_px = px_wdata_in;
    end

    if (reg_valid_in) begin
      unique case (reg_req_in.addr)
        boot_map_pkg::DWAIT_OFFSET: begin
          next_reg_rdata = dwait;
          if (reg_req_in.we) begin
            next_dwait = reg_req_in.wdata;
          end
        end
        boot_map_pkg::SYSCTL_OFFSET: begin
          next_reg_rdata = sysctl;
          if (reg_req_in.we) begin
            next_sysctl = reg_req_in.wdata;
            next_sysctl[boot_map_pkg::SC_FORCE_BIT] = 1'b0;
            if (reg_req_in.wdata[boot_map_pkg::SC_FORCE_BIT] && state == boot_map_pkg::ST_RUN) begin
              next_state = boot_map_pkg::ST_BOOT_MEM;
              next_byte_addr = {reg_req_in.wdata[boot_map_pkg::SC_PAGE_LSB +: 3],
                                13'h0000};
              next_word_idx = '0;
              next_byte_sel = '0;
            end
          end
        end
        default: next_reg_rdata = '0;
      endcase
    end

    // External access in progress: count wait states, finish on zero.
    if (ext_active) begin
      if (ext_cnt != 3'h0) begin
        next_ext_cnt = 3'(ext_cnt - 1'b1);
      end else begin
        next_ext_active = 1'b0;
        next_bus.program_space_select_n = 1'b1;
        next_bus.boot_space_select_n = 1'b1;
        next_bus.rd_n = 1'b1;
        next_bus.wr_n = 1'b1;
        next_bus.data_oe_n = '1;
        if (ext_boot) begin
          byte_take = 1'b1;
          byte_val = ext_data_in[15:8];
        end else begin
          next_pm_ack = 1'b1;
          next_pm_rdata = ext_data_in;
          if (!core_pm_req_in.instr && !core_pm_req_in.we) begin
            next_px = ext_data_in[7:0];
          end
        end
      end
    end

    unique case (state)
      boot_map_pkg::ST_SETTLE: begin
        // Only the synchronisers need to fill; the clock keeps running across a reset.
        next_settle = 2'(settle + 1'b1);
        // One extra cycle lets the filtered straps settle after the third stage fills.
        if (settle == 2'(boot_map_pkg::SYNC_SETTLE_CYCLES)) begin
          next_state = boot_map_pkg::ST_DECIDE;
        end
      end
      boot_map_pkg::ST_DECIDE: begin
        next_dwait[boot_map_pkg::DWAIT_ROMEN_BIT] = memory_map_select_pin && boot_source_select_pin;
        next_byte_addr = {sysctl[boot_map_pkg::SC_PAGE_LSB +: 3], 13'h0000};
        next_word_idx = '0;
        next_byte_sel = '0;
        if (memory_map_select_pin) begin
          next_state = boot_map_pkg::ST_RUN;
          next_start_addr = boot_source_select_pin ? boot_map_pkg::STANDALONE_START
            : boot_map_pkg::EXT_START;
        end else if (!br_req) begin
          next_start_addr = boot_map_pkg::RAM_LOW_BASE;
          next_state = boot_source_select_pin ? boot_map_pkg::ST_BOOT_HOST
            : boot_map_pkg::ST_BOOT_MEM;
        end
      end
      boot_map_pkg::ST_BOOT_MEM: begin
        if (!ext_active && !granted && !br_req) begin
          next_ext_active = 1'b1;
          next_ext_boot = 1'b1;
          next_ext_cnt = sysctl[boot_map_pkg::SC_BOOT_WAIT_LSB +: 3];
          next_bus.addr = byte_addr[13:0];
          next_bus.data = {byte_addr[15:14], 22'h000000};
          next_bus.data_oe_n = {2'h0, 22'h3FFFFF};
          next_bus.boot_space_select_n = 1'b0;
          next_bus.rd_n = 1'b0;
        end
      end
      boot_map_pkg::ST_BOOT_HOST: begin
        fifo_ready = 1'b1;
        if (fifo_valid) begin
          byte_take = 1'b1;
          byte_val = fifo_data;
        end
      end
      boot_map_pkg::ST_RUN: begin
        if (core_pm_valid_in && !pm_ack && !ext_active) begin
          if (in_rom) begin
            next_pm_ack = 1'b1;
            next_pm_rdata = rom_data_in;
            if (!core_pm_req_in.instr) begin
              next_px = rom_data_in[7:0];
            end
          end else if (in_ram) begin
            next_pm_ack = 1'b1;
            if (core_pm_req_in.we) begin
              ram_we = 1'b1;
              ram_addr = ram_index;
              ram_wdata = {core_pm_req_in.wdata, px};
            end else begin
              next_pm_rdata = pm_ram[ram_index];
              if (!core_pm_req_in.instr) begin
                next_px = pm_ram[ram_index][7:0];
              end
            end
          end else if (!granted && !br_req) begin
            next_ext_active = 1'b1;
            next_ext_boot = 1'b0;
            next_ext_cnt = sysctl[boot_map_pkg::SC_PM_WAIT_LSB +: 3];
            next_bus.addr = core_pm_req_in.addr;
            next_bus.data = {core_pm_req_in.wdata, px};
            next_bus.data_oe_n = core_pm_req_in.we ? 24'h000000 : 24'hFFFFFF;
            next_bus.program_space_select_n = 1'b0;
            next_bus.wr_n = !core_pm_req_in.we;
            next_bus.rd_n = core_pm_req_in.we;
          end
        end
      end
      default: next_state = boot_map_pkg::ST_SETTLE;
    endcase

    // Three bytes, most significant first, make one program word.
    if (byte_take) begin
      next_byte_addr = 16'(byte_addr + 1'b1);
      if (byte_sel == boot_map_pkg::LAST_BYTE_OF_WORD) begin
        ram_we = 1'b1;
        ram_addr = word_idx;
        ram_wdata = {asm_hi, byte_val};
        next_byte_sel = '0;
        next_word_idx = 11'(word_idx + 1'b1);
        if (word_idx == 11'(BOOT_WORDS - 1)) begin
          next_state = boot_map_pkg::ST_RUN;
        end
      end else begin
        next_asm_hi = {asm_hi[7:0], byte_val};
        next_byte_sel = 2'(byte_sel + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= boot_map_pkg::ST_SETTLE;
      bus <= '{addr: '0, data: '0, data_oe_n: '1, program_space_select_n: 1'b1,
               data_space_select_n: 1'b1, boot_space_select_n: 1'b1, rd_n: 1'b1,
               wr_n: 1'b1};
      dwait <= boot_map_pkg::DWAIT_RESET;
      sysctl <= boot_map_pkg::SYSCTL_RESET;
      reg_rdata <= '0;
      px <= '0;
      mode_status_word <= '0;
      settle <= '0;
      byte_sel <= '0;
      byte_addr <= '0;
      word_idx <= '0;
      asm_hi <= '0;
      ext_active <= 1'b0;
      ext_boot <= 1'b0;
      ext_cnt <= '0;
      granted <= 1'b0;
      pm_ack <= 1'b0;
      pm_rdata <= '0;
      start_addr <= '0;
    end else begin
      state <= next_state;
      bus <= next_bus;
      dwait <= next_dwait;
      sysctl <= next_sysctl;
      reg_rdata <= next_reg_rdata;
      px <= next_px;
      mode_status_word <= next_mode_status_word;
      settle <= next_settle;
      byte_sel <= next_byte_sel;
      byte_addr <= next_byte_addr;
      word_idx <= next_word_idx;
      asm_hi <= next_asm_hi;
      ext_active <= next_ext_active;
      ext_boot <= next_ext_boot;
      ext_cnt <= next_ext_cnt;
      granted <= next_granted;
      pm_ack <= next_pm_ack;
      pm_rdata <= next_pm_rdata;
      start_addr <= next_start_addr;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (ram_we) begin
      pm_ram[ram_addr] <= ram_wdata;
    end
  end

  // A granted bus floats only the data drivers; address, selects and strobes stay driven, strobes high.
  always_comb begin
    ext_bus_out = bus;
    if (granted) begin
      ext_bus_out.data_oe_n = '1;
    end
  end
  assign bus_released_out = granted;
  assign bus_grant_n_out = !granted;
  assign reg_rdata_out = reg_rdata;
  assign core_pm_ack_out = pm_ack;
  assign core_pm_rdata_out = pm_rdata;
  assign mode_status_word_out = mode_status_word;
  assign pm_low_byte_extension_out = px;
  // Core stays in reset, stacks empty and interrupts masked, until the map is decided.
  assign core_reset_out = (state == boot_map_pkg::ST_SETTLE)
    || (state == boot_map_pkg::ST_DECIDE);
  assign core_run_out = (state == boot_map_pkg::ST_RUN) && !granted;
  assign start_address_out = start_addr;

  a_select_gates_strobe: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (!bus.rd_n || !bus.wr_n) |-> (!bus.program_space_select_n || !bus.boot_space_select_n))
    else $error("strobe without space select");
  a_boot_byte_lines: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !bus.boot_space_select_n |-> (bus.data_oe_n[23:22] == 2'h0 && bus.data_oe_n[15:8] == 8'hFF))
    else $error("boot access drives wrong data lines");
  a_no_boot_memory_map_select_pin: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (state == boot_map_pkg::ST_DECIDE && memory_map_select_pin) |=> state == boot_map_pkg::ST_RUN)
    else $error("boot entered with map select high");
  a_standalone_start: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (state == boot_map_pkg::ST_DECIDE && memory_map_select_pin && boot_source_select_pin)
      |=> (start_addr == 14'h0800 && dwait[15]))
    else $error("stand-alone start wrong");
  a_rom_cleared: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (state == boot_map_pkg::ST_DECIDE && !(memory_map_select_pin && boot_source_select_pin)) |=> !dwait[15])
    else $error("rom window left enabled");
  a_boot_waits: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    ($fell(bus.boot_space_select_n) && sysctl[5:3] == 3'h7)
      |-> !bus.boot_space_select_n [*8] ##1 bus.boot_space_select_n)
    else $error("boot wait count wrong");
  a_grant_no_access: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    granted |-> !ext_active)
    else $error("grant during access");
  a_grant_follows: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (br_req && !ext_active) |=> granted)
    else $error("bus request not granted");
  a_host_pull: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fifo_ready |-> state == boot_map_pkg::ST_BOOT_HOST)
    else $error("host bytes drained outside host boot");
  a_mode_status_word_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (state == boot_map_pkg::ST_SETTLE && !mode_status_we_in) |=> mode_status_word == $past(mode_status_word))
    else $error("mode status changed in reset");
  c_mem_boot: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    state == boot_map_pkg::ST_BOOT_MEM ##1 state == boot_map_pkg::ST_RUN);
  c_host_boot: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    state == boot_map_pkg::ST_BOOT_HOST ##1 state == boot_map_pkg::ST_RUN);
  c_ext_pm: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $fell(bus.program_space_select_n));
  c_grant: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) $rose(granted));
endmodule : reset_boot_memory_map_control

/* src/boot_map_pkg.sv */
// Shared constants, states and carriers for the reset, memory map and boot controller.
package boot_map_pkg;
  // Program memory map.
  localparam logic [13:0] RAM_LOW_BASE = 14'h0000;
  localparam logic [13:0] RAM_HIGH_BASE = 14'h3800;
  localparam logic [13:0] ROM_FIRST = 14'h0800;
  localparam logic [13:0] ROM_LAST = 14'h27FF;
  localparam logic [13:0] EXT_START = 14'h0000;
  localparam logic [13:0] STANDALONE_START = 14'h0800;
  localparam int RAM_WORDS = 2048;
  // Memory-mapped control registers in data space.
  localparam logic [13:0] DWAIT_OFFSET = 14'h3FFE;
  localparam logic [13:0] SYSCTL_OFFSET = 14'h3FFF;
  localparam int DWAIT_ROMEN_BIT = 15;
  localparam logic [15:0] DWAIT_RESET = 16'h01FF;
  localparam int SC_PM_WAIT_LSB = 0;
  localparam int SC_BOOT_WAIT_LSB = 3;
  localparam int SC_PAGE_LSB = 6;
  localparam int SC_FORCE_BIT = 9;
  localparam logic [15:0] SYSCTL_RESET = 16'h003F;
  // Boot space: eight pages of 8K bytes, three bytes per program word.
  localparam int PAGE_ADDR_BITS = 13;
  localparam logic [1:0] LAST_BYTE_OF_WORD = 2'h2;
  // Timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int PLL_LOCK_INPUT_CLOCK_CYCLES = 2000;
  localparam int SYNC_SETTLE_CYCLES = 3;

  typedef enum logic [4:0] {
    ST_SETTLE = 5'b00001,
    ST_DECIDE = 5'b00010,
    ST_BOOT_MEM = 5'b00100,
    ST_BOOT_HOST = 5'b01000,
    ST_RUN = 5'b10000
  } boot_state_e;

  typedef struct packed {
    logic we;
    logic instr;
    logic [13:0] addr;
    logic [15:0] wdata;
  } pm_req_s;

  typedef struct packed {
    logic we;
    logic [13:0] addr;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [13:0] addr;
    logic [23:0] data;
    logic [23:0] data_oe_n;
    logic program_space_select_n;
    logic data_space_select_n;
    logic boot_space_select_n;
    logic rd_n;
    logic wr_n;
  } ext_bus_s;
endpackage : boot_map_pkg

/* bench/ext_memory_model.sv */
// Byte-wide boot memory and external program memory on the shared bus.
`timescale 1ns/1ns
module ext_memory_model (
  // Clock
  input wire logic clk_sys_in,
  // Shared bus
  input wire boot_map_pkg::ext_bus_s bus_in,
  output logic [23:0] data_out
);
  logic [23:0] last = 24'h000000;
  logic [15:0] baddr;
  // Unselected lines keep toggling so a stale value never passes for data.
  always_comb begin
    baddr = {bus_in.data[23:22], bus_in.addr};
    data_out = ~last;
    if (!bus_in.boot_space_select_n && !bus_in.rd_n) begin
      data_out[15:8] = baddr[7:0] ^ baddr[15:8] ^ 8'h5A;
    end else if (!bus_in.program_space_select_n && !bus_in.rd_n) begin
      data_out = {bus_in.addr, bus_in.addr[9:0]} ^ 24'h3C3C3C;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    last <= data_out;
  end
endmodule : ext_memory_model

/* bench/reset_boot_memory_map_control_tb.sv */
// Self-checking bench for the reset, memory map and boot controller.
`timescale 1ns/1ns
module reset_boot_memory_map_control_tb;
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, memory_map_select_pin_in = 1'b0;
  logic boot_source_select_pin_in = 1'b0, bus_hold_request_n_in = 1'b1;
  logic host_port_valid_in = 1'b0, reg_valid_in = 1'b0, core_pm_valid_in = 1'b0;
  logic mode_status_we_in = 1'b0, px_we_in = 1'b0;
  logic [7:0] host_port_data_in = 8'h00, px_wdata_in = 8'h00;
  logic [6:0] mode_status_wdata_in = 7'h00;
  boot_map_pkg::pm_req_s core_pm_req_in = '0;
  boot_map_pkg::reg_req_s reg_req_in = '0;
  boot_map_pkg::ext_bus_s ext_bus_out;
  logic [23:0] ext_data_in, core_pm_rdata_out, rom_data_in;
  logic [15:0] reg_rdata_out;
  logic [13:0] start_address_out;
  logic [12:0] rom_addr_out;
  logic [7:0] pm_low_byte_extension_out;
  logic [6:0] mode_status_word_out;
  logic bus_grant_n_out, bus_released_out, host_port_ready_out, core_pm_ack_out;
  logic core_reset_out, core_run_out;
  logic [2:0] w;
  logic [7:0] hb [12];
  int miscompares = 0, num_checks = 0, seed = 32'h3bb03ef1, n, sc;
  always #50 clk_sys_in = ~clk_sys_in;
  assign rom_data_in = {11'h000, rom_addr_out} ^ 24'hA5A5A5;
  reset_boot_memory_map_control #(.BOOT_WORDS(4)) u_reset_boot_memory_map_control (
    .clk_sys_in, .rst_n_in, .memory_map_select_pin_in, .boot_source_select_pin_in,
    .bus_hold_request_n_in, .bus_grant_n_out, .ext_bus_out, .bus_released_out,
    .ext_data_in, .host_port_valid_in, .host_port_ready_out, .host_port_data_in,
    .core_pm_valid_in, .core_pm_req_in, .core_pm_ack_out, .core_pm_rdata_out,
    .rom_addr_out, .rom_data_in, .reg_valid_in, .reg_req_in, .reg_rdata_out,
    .mode_status_we_in, .mode_status_wdata_in, .mode_status_word_out, .px_we_in,
    .px_wdata_in, .pm_low_byte_extension_out, .core_reset_out, .core_run_out,
    .start_address_out);
  ext_memory_model u_ext_memory_model (.clk_sys_in, .bus_in(ext_bus_out),
    .data_out(ext_data_in));
  function automatic logic [7:0] bb(input logic [15:0] b);
    return b[7:0] ^ b[15:8] ^ 8'h5A;
  endfunction : bb
  function automatic logic [23:0] ew(input logic [13:0] a);
    return {a, a[9:0]} ^ 24'h3C3C3C;
  endfunction : ew
  task automatic results;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string s, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys_in);
  endtask : tick
  task automatic bound(input int lim);
    if (n >= lim) begin
      miscompares++;
      results();
    end
  endtask : bound
  task automatic boot(input logic m, input logic b);
    rst_n_in = 1'b0;
    memory_map_select_pin_in = m;
    boot_source_select_pin_in = b;
    tick(8);
    chk("reset", 24'({ext_bus_out.program_space_select_n, ext_bus_out.data_space_select_n,
      ext_bus_out.boot_space_select_n, ext_bus_out.rd_n, ext_bus_out.wr_n, core_reset_out,
      core_run_out, mode_status_word_out}), 24'h003F00);
    rst_n_in = 1'b1;
  endtask : boot
  task automatic wrun;
    n = 0;
    while (core_run_out !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    bound(3000);
  endtask : wrun
  task automatic rg(input logic we, input logic [13:0] a, input logic [15:0] d);
    reg_valid_in = 1'b1;
    reg_req_in = '{we, a, d};
    tick(1);
    reg_valid_in = 1'b0;
    tick(1);
  endtask : rg
  task automatic pm(input logic i, input logic [13:0] a);
    core_pm_valid_in = 1'b1;
    core_pm_req_in = '{1'b0, i, a, 16'h0000};
    n = 0;
    sc = 0;
    do begin
      tick(1);
      n++;
      sc += int'(ext_bus_out.program_space_select_n === 1'b0 && ext_bus_out.rd_n === 1'b0);
    end while (core_pm_ack_out !== 1'b1 && n < 100);
    bound(100);
    core_pm_valid_in = 1'b0;
    tick(1);
  endtask : pm
  initial begin
    boot(1'b0, 1'b0);
    rg(1'b0, 14'h3FFE, 16'h0000);
    chk("dwait", 24'(reg_rdata_out), 24'h0001FF);
    rg(1'b0, 14'h3FFF, 16'h0000);
    chk("sysctl", 24'(reg_rdata_out), 24'h00003F);
    wrun();
    chk("start", 24'(start_address_out), 24'h000000);
    for (int i = 0; i < 4; i++) begin
      pm(1'b1, 14'(i));
      chk("ram", core_pm_rdata_out, {bb(16'(3*i)), bb(16'(3*i+1)), bb(16'(3*i+2))});
    end
    for (int r = 0; r < 2; r++) begin
      rg(1'b1, 14'h3FFE, {r[0], 15'h01FF});
      pm(1'b1, 14'h0805);
      chk("window", core_pm_rdata_out, r ? 24'hA5A5A0 : ew(14'h0805));
    end
    w = 3'($random(seed));
    rg(1'b1, 14'h3FFF, {10'h000, 3'h7, w});
    pm(1'b0, 14'h3000);
    chk("wait", 24'(sc), 24'(w) + 24'h1);
    chk("px", 24'(pm_low_byte_extension_out), ew(14'h3000) & 24'h0000FF);
    mode_status_wdata_in = 7'($random(seed));
    mode_status_we_in = 1'b1;
    tick(1);
    mode_status_we_in = 1'b0;
    chk("mode_status_word", 24'(mode_status_word_out), 24'(mode_status_wdata_in));
    bus_hold_request_n_in = 1'b0;
    tick(6);
    chk("grant", 24'({bus_grant_n_out, bus_released_out, core_run_out}), 24'h2);
    bus_hold_request_n_in = 1'b1;
    tick(6);
    chk("ungrant", 24'({bus_grant_n_out, core_run_out}), 24'h3);
    rg(1'b1, 14'h3FFF, 16'h0280);
    tick(2);
    chk("forced", 24'(core_run_out), 24'h0);
    wrun();
    pm(1'b1, 14'h0000);
    chk("page", core_pm_rdata_out, {bb(16'h4000), bb(16'h4001), bb(16'h4002)});
    boot(1'b1, 1'b0);
    wrun();
    chk("ext start", 24'(start_address_out), 24'h000000);
    pm(1'b1, 14'h0000);
    chk("ext low", core_pm_rdata_out, ew(14'h0000));
    boot(1'b1, 1'b1);
    wrun();
    chk("rom start", 24'(start_address_out), 24'h000800);
    rg(1'b0, 14'h3FFE, 16'h0000);
    chk("rom enable", 24'(reg_rdata_out), 24'h0081FF);
    boot(1'b0, 1'b1);
    // Twelve bytes stay below the FIFO depth, so ready never drops here.
    for (int i = 0; i < 12; i++) begin
      hb[i] = 8'($random(seed));
      host_port_data_in = hb[i];
      host_port_valid_in = 1'b1;
      chk("host ready", 24'(host_port_ready_out), 24'h000001);
      tick(1);
    end
    host_port_valid_in = 1'b0;
    wrun();
    for (int i = 0; i < 4; i++) begin
      pm(1'b1, 14'(i));
      chk("host", core_pm_rdata_out, {hb[3*i], hb[3*i+1], hb[3*i+2]});
    end
    results();
  end
endmodule : reset_boot_memory_map_control_tb
